// ===== verilog/acq_io_pkg.sv
package acq_io_pkg;
  // ==========================================================================
  // widths
  localparam int ACC_W   = 12;
  localparam int INSTR_W = 9;
  localparam int ADDR_W  = 13;

  // ==========================================================================
  // timing, at a 10 ns reference clock
  localparam int CLK_PERIOD_NS    = 10;
  localparam int XFER_DELAY_NS    = 1000;
  localparam int XFER_DELAY_CYC   = (XFER_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_FREQ_KHZ    = 100;
  localparam int TICK_HALF_CYC    = (1000000 / CLK_PERIOD_NS) / TICK_FREQ_KHZ / 2;
  localparam int CLEAR_PULSE_NS   = 500;
  localparam int CLEAR_PULSE_CYC  = CLEAR_PULSE_NS / CLK_PERIOD_NS;
  localparam int SKIP_PULSE_CYC   = 1;
  localparam int CONV_TIME_CYC    = 20;
  localparam int CNT_W            = 10;  // must hold the timing half period count

  // ==========================================================================
  // instruction decode: the low three bits (6..8) select the operation
  localparam logic [2:0] OP_SKIP_READY = 3'h1;
  localparam logic [2:0] OP_ACQ_ON     = 3'h2;
  localparam logic [2:0] OP_ACQ_OFF    = 3'h3;
  localparam logic [2:0] OP_TICK_ON    = 3'h4;
  localparam logic [2:0] OP_TICK_OFF   = 3'h5;

  // ==========================================================================
  // fifo
  localparam int FIFO_DEPTH = 16;
endpackage

// ===== verilog/acq_io_if.sv
`timescale 1ns/1ns
// ==========================================================================
// pins between control module and its computer/converter partners
interface acq_io_if;
  logic                 skip_request_n;
  logic                 cpu_running_n;
  logic [11:0]          acc_out_bits_n;
  logic [8:0]           io_instr_bits_n;
  logic                 io_ctrl_instr_n;
  logic                 start_clear_n;
  logic                 b_level_irq_enable_n;
  logic                 low_level_irq_enable_n;
  logic [12:0]          conv_addr_bits_n;
  logic                 acquire_n;
  logic                 conv_transfer_n;
  logic                 conv_busy_n;
  logic                 conv_ready_n;
  logic                 clock_time_sel_n;
  logic                 conv_clear_n;
  logic                 invalid_data_flag;
  logic                 gated_timing_out;

  modport device (
    output skip_request_n, acquire_n, conv_transfer_n, conv_clear_n, gated_timing_out,
    input  cpu_running_n, acc_out_bits_n, io_instr_bits_n, io_ctrl_instr_n, start_clear_n,
           b_level_irq_enable_n, low_level_irq_enable_n, conv_addr_bits_n, conv_busy_n,
           conv_ready_n, clock_time_sel_n, invalid_data_flag
  );
  modport partner (
    input  skip_request_n, acquire_n, conv_transfer_n, conv_clear_n, gated_timing_out,
    output cpu_running_n, acc_out_bits_n, io_instr_bits_n, io_ctrl_instr_n, start_clear_n,
           b_level_irq_enable_n, low_level_irq_enable_n, conv_addr_bits_n, conv_busy_n,
           conv_ready_n, clock_time_sel_n, invalid_data_flag
  );
endinterface

// ===== verilog/sync_fifo.sv
`timescale 1ns/1ns
// ==========================================================================
// synchronous fifo, valid/ready both sides
module sync_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  wire              push;
  wire              pop;

  // pointers carry one extra bit so full and empty are told apart
  assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data  = mem[rd_q[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage has no reset, only pointers do
  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem[wr_q[AW-1:0]] <= in_data;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else if (flush)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
    end
  end
endmodule

// ===== verilog/acq_control_io.sv
`timescale 1ns/1ns
module acq_control_io
  import acq_io_pkg::*;
#(
  parameter int FIFO_W     = acq_io_pkg::ADDR_W,
  parameter int FIFO_DEPTH = acq_io_pkg::FIFO_DEPTH
) (
  input  wire logic                         ref_clk,
  input  wire logic                         arst_n,
  acq_io_if.device                          link,
  output logic [acq_io_pkg::ADDR_W-1:0]     event_addr,
  output logic                              event_valid,
  input  wire logic                         event_ready,
  output logic                              acq_enabled,
  output logic                              conv_busy,
  output logic                              clock_time_sel,
  output logic [acq_io_pkg::ACC_W-1:0]      last_acc_word,
  output logic                              irq_b_allowed,
  output logic                              irq_low_allowed
);
  import acq_io_pkg::*;

  typedef enum logic [2:0] {IDLE, WAIT_DELAY, STROBE, PUSH, CLEAR} xfer_e;

  // ==========================================================================
  // input synchronisers, two stages each
  // the alter line rides inverted so the all-ones reset reads as idle everywhere
  localparam int SYN_W = 9 + ACC_W + INSTR_W + ADDR_W;
  logic [SYN_W-1:0] s1_q;
  logic [SYN_W-1:0] s2_q;
  logic             alt_s3_q;
  wire  [SYN_W-1:0] raw_in = {~link.invalid_data_flag, link.cpu_running_n, link.io_ctrl_instr_n,
                              link.start_clear_n, link.b_level_irq_enable_n, link.low_level_irq_enable_n,
                              link.conv_busy_n, link.conv_ready_n, link.clock_time_sel_n,
                              link.acc_out_bits_n, link.io_instr_bits_n, link.conv_addr_bits_n};

  // the first stage is never looked at
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_q     <= '1;
      s2_q     <= '1;
      alt_s3_q <= 1'b0;
    end
    else
    begin
      s1_q     <= raw_in;
      s2_q     <= s1_q;
      alt_s3_q <= ~s2_q[SYN_W-1];  // third stage only feeds the edge detector
    end
  end

  // ==========================================================================
  // decode of synchronised inputs, active-low lines inverted here
  wire              alt_s     = ~s2_q[SYN_W-1];
  wire              run_s     = ~s2_q[SYN_W-2];
  wire              ioc_s     = ~s2_q[SYN_W-3];
  wire              start_clear_n_s   = ~s2_q[SYN_W-4];
  wire              irqb_en_s = ~s2_q[SYN_W-5];
  wire              irql_en_s = ~s2_q[SYN_W-6];
  wire              busy_s    = ~s2_q[SYN_W-7];
  wire              ready_s   = ~s2_q[SYN_W-8];
  wire              ctime_s   = ~s2_q[SYN_W-9];
  wire [ACC_W-1:0]  acc_s     = ~s2_q[INSTR_W+ADDR_W +: ACC_W];
  wire [INSTR_W-1:0] instr_s  = ~s2_q[ADDR_W +: INSTR_W];
  wire [ADDR_W-1:0] addr_s    = ~s2_q[ADDR_W-1:0];
  wire              alt_rise  = alt_s && !alt_s3_q;

  // bit 0 is the most significant on the wire; bits 6..8 hold the operation
  wire [2:0] op_s = {instr_s[INSTR_W-3], instr_s[INSTR_W-2], instr_s[INSTR_W-1]};

  // ==========================================================================
  // instruction strobe: act once per qualifier assertion
  logic ioc_d1_q;
  wire  ioc_new = ioc_s && !ioc_d1_q && run_s;

  logic acq_q;
  logic tick_en_q;
  logic skip_n_q;
  logic [ACC_W-1:0] acc_q;
  xfer_e state_q;
  xfer_e state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [ADDR_W-1:0] addr_q;
  logic dummy_q;
  wire  fifo_in_ready;

  wire do_skip = ioc_new && op_s == OP_SKIP_READY && event_valid;

  // control register updates; start clear wins over everything
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ioc_d1_q  <= 1'b0;
      acq_q     <= 1'b0;
      tick_en_q <= 1'b0;
      skip_n_q  <= 1'b1;
      acc_q     <= '0;
    end
    else if (start_clear_n_s)
    begin
      ioc_d1_q  <= 1'b0;
      acq_q     <= 1'b0;
      tick_en_q <= 1'b0;
      skip_n_q  <= 1'b1;
    end
    else
    begin
      ioc_d1_q  <= ioc_s;
      skip_n_q  <= !do_skip;
      acq_q     <= (ioc_new && op_s == OP_ACQ_ON) || (acq_q && !(ioc_new && op_s == OP_ACQ_OFF));
      tick_en_q <= (ioc_new && op_s == OP_TICK_ON) || (tick_en_q && !(ioc_new && op_s == OP_TICK_OFF));
      if (ioc_new)
        acc_q <= acc_s;
    end
  end

  // ==========================================================================
  // converter transfer sequence
  wire delay_done = cnt_q == CNT_W'(XFER_DELAY_CYC - 1);
  wire clr_done   = cnt_q == CNT_W'(CLEAR_PULSE_CYC - 1);

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      IDLE:       if (ready_s || alt_rise) state_d = WAIT_DELAY;
      WAIT_DELAY: if (delay_done) state_d = STROBE;
      STROBE:     state_d = PUSH;
      PUSH:       if (dummy_q || fifo_in_ready) state_d = CLEAR;
      CLEAR:      if (clr_done) state_d = IDLE;
    endcase
  end

  // the fifo stalls the sequence in PUSH, holding the strobe low until room
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= IDLE;
      cnt_q   <= '0;
      addr_q  <= '0;
      dummy_q <= 1'b0;
    end
    else if (start_clear_n_s)
    begin
      state_q <= IDLE;
      cnt_q   <= '0;
      dummy_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= (state_d != state_q) ? '0 : cnt_q + 1'b1;
      if (state_q == IDLE)
        dummy_q <= alt_rise && !ready_s;
      if (state_q == STROBE)
        addr_q <= addr_s;
    end
  end

  sync_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) sync_fifo_inst (
    .ref_clk   (ref_clk),
    .arst_n    (arst_n),
    .flush     (start_clear_n_s),
    .in_data   (addr_q),
    .in_valid  (state_q == PUSH && !dummy_q),
    .in_ready  (fifo_in_ready),
    .out_data  (event_addr),
    .out_valid (event_valid),
    .out_ready (event_ready)
  );

  // ==========================================================================
  // gated 100 kHz timing
  logic [CNT_W-1:0] tick_cnt_q;
  logic tick_q;
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end
    else if (!tick_en_q)
    begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end
    else if (tick_cnt_q == CNT_W'(TICK_HALF_CYC - 1))
    begin
      tick_cnt_q <= '0;
      tick_q     <= ~tick_q;
    end
    else
      tick_cnt_q <= tick_cnt_q + 1'b1;
  end

  // ==========================================================================
  // registered outputs
  logic xfer_n_q;
  logic clr_n_q;
  logic busy_q;
  logic ctime_q;
  logic irqb_q;
  logic irql_q;
  logic acq_n_q;
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      xfer_n_q <= 1'b1;
      clr_n_q  <= 1'b1;
      busy_q   <= 1'b0;
      ctime_q  <= 1'b0;
      irqb_q   <= 1'b0;
      irql_q   <= 1'b0;
      acq_n_q  <= 1'b1;
    end
    else
    begin
      xfer_n_q <= !(state_d == STROBE || state_d == PUSH);
      clr_n_q  <= !(state_d == CLEAR);
      busy_q   <= busy_s;
      ctime_q  <= ctime_s;
      irqb_q   <= irqb_en_s;
      irql_q   <= irql_en_s;
      acq_n_q  <= !acq_q;
    end
  end

  assign link.skip_request_n  = skip_n_q;
  assign link.acquire_n       = acq_n_q;
  assign link.conv_transfer_n = xfer_n_q;
  assign link.conv_clear_n    = clr_n_q;
  assign link.gated_timing_out = tick_q;
  assign acq_enabled     = acq_q;
  assign conv_busy       = busy_q;
  assign clock_time_sel  = ctime_q;
  assign last_acc_word   = acc_q;
  assign irq_b_allowed   = irqb_q;
  assign irq_low_allowed = irql_q;
endmodule

// ===== verilog/acq_partner_end.sv
`timescale 1ns/1ns
// ==========================================================================
// far end: computer io port plus a simple converter
module acq_partner_end
  import acq_io_pkg::*;
(
  input  wire logic                         ref_clk,
  input  wire logic                         arst_n,
  acq_io_if.partner                         link,
  input  wire logic                         cpu_running,
  input  wire logic                         start_clear,
  input  wire logic                         irq_b_enable,
  input  wire logic                         irq_low_enable,
  input  wire logic                         instr_valid,
  input  wire logic [acq_io_pkg::INSTR_W-1:0] instr_word,
  input  wire logic [acq_io_pkg::ACC_W-1:0] acc_word,
  input  wire logic                         pulse_in,
  input  wire logic [acq_io_pkg::ADDR_W-1:0] pulse_addr,
  input  wire logic                         pulse_invalid,
  input  wire logic                         clock_time_opt,
  output logic                              skip_seen,
  output logic                              acquiring,
  output logic                              timing_level
);
  import acq_io_pkg::*;

  logic             busy_q;
  logic             ready_q;
  logic             alt_q;
  logic [ADDR_W-1:0] addr_q;
  logic [CNT_W-1:0] cnt_q;
  logic             skip_q;
  logic             acq_q;
  logic             tim_q;

  // converter: accepts a pulse only while permitted and free
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busy_q  <= 1'b0;
      ready_q <= 1'b0;
      alt_q   <= 1'b0;
      addr_q  <= '0;
      cnt_q   <= '0;
    end
    else if (!link.conv_clear_n)
    begin
      busy_q  <= 1'b0;
      ready_q <= 1'b0;
      alt_q   <= 1'b0;
      cnt_q   <= '0;
    end
    else if (pulse_in && !busy_q && !link.acquire_n)
    begin
      busy_q <= 1'b1;
      addr_q <= pulse_addr;
      alt_q  <= 1'b0;
      cnt_q  <= '0;
    end
    else if (busy_q && !ready_q && !alt_q)
    begin
      cnt_q <= cnt_q + 1'b1;
      if (cnt_q == CNT_W'(CONV_TIME_CYC - 1))
      begin
        if (pulse_invalid)
          alt_q <= 1'b1;
        else
          ready_q <= 1'b1;
      end
    end
  end

  // observed outputs registered
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      skip_q <= 1'b0;
      acq_q  <= 1'b0;
      tim_q  <= 1'b0;
    end
    else
    begin
      skip_q <= !link.skip_request_n;
      acq_q  <= !link.acquire_n;
      tim_q  <= link.gated_timing_out;
    end
  end

  // computer and converter side lines, all active low except invalid_data_flag
  assign link.cpu_running_n          = ~cpu_running;
  assign link.start_clear_n          = ~start_clear;
  assign link.b_level_irq_enable_n   = ~irq_b_enable;
  assign link.low_level_irq_enable_n = ~irq_low_enable;
  assign link.io_ctrl_instr_n        = ~instr_valid;
  assign link.io_instr_bits_n        = ~instr_word;
  assign link.acc_out_bits_n         = ~acc_word;
  assign link.conv_addr_bits_n       = ~addr_q;
  assign link.conv_busy_n            = ~busy_q;
  assign link.conv_ready_n           = ~ready_q;
  assign link.clock_time_sel_n       = ~clock_time_opt;
  assign link.invalid_data_flag      = alt_q;
  assign skip_seen    = skip_q;
  assign acquiring    = acq_q;
  assign timing_level = tim_q;
endmodule

// ===== tb/acq_io_checker.sv
`timescale 1ns/1ns
// ==========================================================================
// wire-level checks on the link between the two ends
module acq_io_checker (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic skip_request_n,
  input wire logic io_ctrl_instr_n,
  input wire logic acquire_n,
  input wire logic conv_transfer_n,
  input wire logic conv_busy_n,
  input wire logic conv_ready_n,
  input wire logic conv_clear_n,
  input wire logic invalid_data_flag,
  input wire logic gated_timing_out
);
  import acq_io_pkg::*;
  int clr_cnt_q;
  int rdy_cnt_q;
  int hi_cnt_q;

  // ==========================================================================
  // run lengths: clear low, ready low, timing high (count from the first sample)
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      clr_cnt_q <= 0;
      rdy_cnt_q <= 0;
      hi_cnt_q  <= 0;
    end
    else
    begin
      clr_cnt_q <= conv_clear_n ? 0 : clr_cnt_q + 1;
      rdy_cnt_q <= conv_ready_n ? 0 : rdy_cnt_q + 1;
      hi_cnt_q  <= gated_timing_out ? hi_cnt_q + 1 : 0;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // ==========================================================================
  // assertions
  chk_skip_one_cycle:
    assert property ($fell(skip_request_n) |=> skip_request_n)
    else $error("skip request held low beyond one cycle");
  chk_skip_after_instr:
    assert property ($fell(skip_request_n) |-> !$past(io_ctrl_instr_n, 3) || !$past(io_ctrl_instr_n, 4))
    else $error("skip request without a qualified instruction three to four cycles before");
  chk_acq_gates_busy:
    assert property ($fell(conv_busy_n) |-> !$past(acquire_n) || !$past(acquire_n, 2))
    else $error("converter started while acquisition inhibited");
  chk_strobe_delay:
    assert property ($fell(conv_transfer_n) && !conv_ready_n
                     |-> rdy_cnt_q >= XFER_DELAY_CYC && rdy_cnt_q <= XFER_DELAY_CYC + 8)
    else $error("transfer strobe not about one microsecond after ready");
  chk_strobe_hold:
    assert property ($fell(conv_transfer_n) |=> !conv_transfer_n)
    else $error("transfer strobe shorter than two cycles");
  chk_strobe_not_in_clear:
    assert property ($fell(conv_transfer_n) |-> conv_clear_n)
    else $error("transfer strobe started during a clear pulse");
  chk_clear_after_strobe:
    assert property ($fell(conv_clear_n) |-> !$past(conv_transfer_n) || !$past(conv_transfer_n, 2)
                     || !$past(conv_transfer_n, 3))
    else $error("clear pulse without a transfer just before");
  chk_clear_width:
    assert property ($rose(conv_clear_n) |-> clr_cnt_q == CLEAR_PULSE_CYC)
    else $error("clear pulse width wrong");
  chk_ready_released:
    assert property ($rose(conv_clear_n) |-> conv_ready_n)
    else $error("converter ready still low after clear");
  chk_timing_half:
    assert property (gated_timing_out |-> hi_cnt_q < TICK_HALF_CYC)
    else $error("timing output high longer than half a period");

  // main scenarios reached
  cov_skip: cover property ($fell(skip_request_n));
  cov_dummy: cover property ($fell(conv_transfer_n) && invalid_data_flag);
  cov_timing: cover property ($rose(gated_timing_out));
endmodule

// ===== tb/acquisition_control_io_interface_tb.sv
`timescale 1ns/1ns
// ==========================================================================
// both ends joined; bench drives the computer/converter side and the event sink
module acquisition_control_io_interface_tb;
  import acq_io_pkg::*;
  logic                ref_clk, arst_n, cpu_running, start_clear, irq_b_enable, irq_low_enable;
  logic                instr_valid, pulse_in, pulse_invalid, clock_time_opt, event_ready;
  logic [INSTR_W-1:0]  instr_word;
  logic [ACC_W-1:0]    acc_word, last_acc_word;
  logic [ADDR_W-1:0]   pulse_addr, event_addr;
  logic                event_valid, acq_enabled, conv_busy, clock_time_sel, irq_b_allowed, irq_low_allowed;
  logic                skip_seen, acquiring, timing_level;
  int                  bad_count, compares, k, n, hi, skips;

  acq_io_if acq_io_if_inst ();
  acq_control_io acq_control_io_inst (.ref_clk(ref_clk), .arst_n(arst_n), .link(acq_io_if_inst),
    .event_addr(event_addr), .event_valid(event_valid), .event_ready(event_ready),
    .acq_enabled(acq_enabled), .conv_busy(conv_busy), .clock_time_sel(clock_time_sel),
    .last_acc_word(last_acc_word), .irq_b_allowed(irq_b_allowed), .irq_low_allowed(irq_low_allowed));
  acq_partner_end acq_partner_end_inst (.ref_clk(ref_clk), .arst_n(arst_n), .link(acq_io_if_inst),
    .cpu_running(cpu_running), .start_clear(start_clear), .irq_b_enable(irq_b_enable),
    .irq_low_enable(irq_low_enable), .instr_valid(instr_valid), .instr_word(instr_word),
    .acc_word(acc_word), .pulse_in(pulse_in), .pulse_addr(pulse_addr), .pulse_invalid(pulse_invalid),
    .clock_time_opt(clock_time_opt), .skip_seen(skip_seen), .acquiring(acquiring),
    .timing_level(timing_level));
  acq_io_checker acq_io_checker_inst (.ref_clk(ref_clk), .arst_n(arst_n),
    .skip_request_n(acq_io_if_inst.skip_request_n), .io_ctrl_instr_n(acq_io_if_inst.io_ctrl_instr_n),
    .acquire_n(acq_io_if_inst.acquire_n), .conv_transfer_n(acq_io_if_inst.conv_transfer_n),
    .conv_busy_n(acq_io_if_inst.conv_busy_n), .conv_ready_n(acq_io_if_inst.conv_ready_n),
    .conv_clear_n(acq_io_if_inst.conv_clear_n), .invalid_data_flag(acq_io_if_inst.invalid_data_flag),
    .gated_timing_out(acq_io_if_inst.gated_timing_out));

  // ==========================================================================
  // clock and shared tasks
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // inputs always move 1 ns after the edge, so outputs are settled when sampled
  task automatic tick(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (bad_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // one io instruction; qualifier held six cycles, then released three
  task automatic io_cmd(input logic [2:0] op, input logic [11:0] acc);
    instr_word = {op[0], op[1], op[2], 6'h00};  // bit 0 is the msb, op sits in bits 6..8
    acc_word = acc;
    instr_valid = 1'b1;
    skips = 0;
    repeat (6)
    begin
      tick(1);
      if (acq_io_if_inst.skip_request_n === 1'b0) skips++;
      if (skip_seen === 1'b1) skips++;
    end
    check(acq_io_if_inst.acc_out_bits_n, 12'(~acc));
    check(acq_io_if_inst.io_instr_bits_n, 9'(~{op[0], op[1], op[2], 6'h00}));
    instr_valid = 1'b0;
    tick(3);
    if (cpu_running) check(last_acc_word, acc);
  endtask

  // one converter event; with stall set, return once the strobe is seen
  task automatic conv_event(input logic [12:0] a, input logic inv, input logic stall);
    int st, i;
    st = 0;
    pulse_addr = a;
    pulse_invalid = inv;
    pulse_in = 1'b1;
    tick(1);
    pulse_in = 1'b0;
    tick(4);
    check(conv_busy, 1'b1);
    for (i = 0; i < 600 && st < (stall ? 1 : 3); i++)
    begin
      if (st == 0 && acq_io_if_inst.conv_transfer_n === 1'b0)
      begin
        st = 1;
        if (!inv) check(acq_io_if_inst.conv_addr_bits_n, 13'(~a));
      end
      else if (st == 1 && acq_io_if_inst.conv_clear_n === 1'b0) st = 2;
      else if (st == 2 && acq_io_if_inst.conv_clear_n === 1'b1) st = 3;
      if (st < (stall ? 1 : 3)) tick(1);
    end
    pulse_invalid = 1'b0;
    if (st < (stall ? 1 : 3))
    begin
      bad_count++;
      end_of_test();
    end
    tick(3);
  endtask

  task automatic pop(input logic [12:0] a);
    int i;
    for (i = 0; i < 400 && event_valid !== 1'b1; i++) tick(1);
    if (event_valid !== 1'b1)
    begin
      bad_count++;
      end_of_test();
    end
    check(event_addr, a);
    event_ready = 1'b1;
    tick(1);
    event_ready = 1'b0;
    tick(1);
  endtask

  // ==========================================================================
  // main sequence
  initial
  begin
    {cpu_running, start_clear, irq_b_enable, irq_low_enable, instr_valid} = 5'h00;
    {pulse_in, pulse_invalid, clock_time_opt, event_ready} = 4'h0;
    instr_word = 9'h000;
    acc_word = 12'h000;
    pulse_addr = 13'h0000;
    bad_count = 0;
    compares = 0;
    arst_n = 1'b0;
    tick(2);
    arst_n = 1'b1;
    check(acq_io_if_inst.skip_request_n, 1'b1);
    check(acq_io_if_inst.conv_transfer_n, 1'b1);
    check(acq_io_if_inst.conv_clear_n, 1'b1);
    check(acq_io_if_inst.acquire_n, 1'b1);
    check(acq_io_if_inst.gated_timing_out, 1'b0);
    check(event_valid, 1'b0);
    tick(2);
    // halted computer: instruction must be ignored
    io_cmd(OP_ACQ_ON, 12'hA5C);
    check(acq_io_if_inst.acquire_n, 1'b1);
    cpu_running = 1'b1;
    tick(4);
    io_cmd(OP_ACQ_ON, 12'h801);
    check(acq_io_if_inst.acquire_n, 1'b0);
    check(acq_enabled, 1'b1);
    check(acquiring, 1'b1);
    io_cmd(OP_SKIP_READY, 12'h3F0);
    check(16'(skips), 16'h0000);
    conv_event(13'h1ABC, 1'b0, 1'b0);
    io_cmd(OP_SKIP_READY, 12'h0F3);
    check(16'(skips), 16'h0002);
    pop(13'h1ABC);
    conv_event(13'h0F0F, 1'b1, 1'b0);
    check(event_valid, 1'b0);
    // fill the buffer, then one more event stalls the strobe low
    for (k = 0; k < FIFO_DEPTH; k++) conv_event(13'h1FFF ^ 13'(k * 37), 1'b0, 1'b0);
    conv_event(13'h0001, 1'b0, 1'b1);
    tick(300);
    check(acq_io_if_inst.conv_transfer_n, 1'b0);
    for (k = 0; k < FIFO_DEPTH; k++) pop(13'h1FFF ^ 13'(k * 37));
    pop(13'h0001);
    tick(80);
    io_cmd(OP_ACQ_OFF, 12'h555);
    pulse_in = 1'b1;
    tick(1);
    pulse_in = 1'b0;
    tick(200);
    check(acq_io_if_inst.conv_transfer_n, 1'b1);
    check(event_valid, 1'b0);
    check(acquiring, 1'b0);
    // timing output: one full period holds exactly half high
    io_cmd(OP_TICK_ON, 12'hFFF);
    for (n = 0; n < 1100 && acq_io_if_inst.gated_timing_out !== 1'b1; n++) tick(1);
    if (acq_io_if_inst.gated_timing_out !== 1'b1)
    begin
      bad_count++;
      end_of_test();
    end
    // the far end's registered copy lags one cycle, so it too is high for half the window
    hi = 0;
    repeat (2 * TICK_HALF_CYC)
    begin
      if (acq_io_if_inst.gated_timing_out === 1'b1) hi++;
      if (timing_level === 1'b1) hi++;
      tick(1);
    end
    check(16'(hi), 16'(2 * TICK_HALF_CYC));
    io_cmd(OP_TICK_OFF, 12'h000);
    hi = 0;
    repeat (2 * TICK_HALF_CYC)
    begin
      if (acq_io_if_inst.gated_timing_out !== 1'b0) hi++;
      if (timing_level !== 1'b0) hi++;
      tick(1);
    end
    check(16'(hi), 16'h0000);
    // every combination of the two enable lines, the option line following the low-level enable
    for (k = 0; k < 4; k++)
    begin
      irq_b_enable = k[0];
      irq_low_enable = k[1];
      clock_time_opt = k[1];
      tick(4);
      check(irq_b_allowed, k[0]);
      check(irq_low_allowed, k[1]);
      check(clock_time_sel, k[1]);
    end
    // start clear with a word waiting and acquisition on
    io_cmd(OP_ACQ_ON, 12'h123);
    conv_event(13'h0155, 1'b0, 1'b0);
    start_clear = 1'b1;
    tick(3);
    start_clear = 1'b0;
    tick(4);
    check(acq_io_if_inst.acquire_n, 1'b1);
    check(event_valid, 1'b0);
    end_of_test();
  end
endmodule
